// File: core/dxrh_handshake.sv
/*
  external dma request arbitration hook and active-low grant generation.
  assumes the channel engine runs bursts on request and reports done, and
  that the arbiter honours ext_low_prio for its next decision.
*/
// Overview of operation
// R1: the external channel bursts only once the arbiter names it highest priority.
// R2: the peripheral keeps its request asserted until a burst services it.
// R3: each accepted request leads to at least one whole burst on its channel.
// R4: grant is active low, low when asserted and high otherwise.
// R5: grant asserts only during a burst on a channel sourced by the external request.
// R6: grant also needs the channel's request-enable and channel-enable bits set.
// R7: grant also needs the external request asserted while the burst runs.
// R8: from grant assertion until burst end the request level is ignored.
// R9: with another request pending, the external channel goes low priority next time.
// R10: grant stays asserted at least eight bus clocks even if request drops at once.
// R11: the peripheral releases request within about nine clocks after grant.
// R12: the peripheral releases request within about eight clocks after first read.
// R13: the peripheral releases request within about three clocks after first write.
// R14: all windows count periods of the system bus clock.
// R15: the external request is synchronised into the bus clock before use.
module dxrh_handshake
  import dxrh_pkg::*;
#(
  parameter int GRANT_MIN_CYC = dxrh_pkg::DXRH_GRANT_MIN_CYC
) (
  input wire logic clock, // system bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic ext_req_pin, // external request pin, active high
  input wire logic [dxrh_pkg::DXRH_SRC_W-1:0] request_source_select, // channel source
  input wire logic [dxrh_pkg::DXRH_SRC_W-1:0] ext_source_code, // code of ext input
  input wire logic request_enable_bit, // channel request enable
  input wire logic channel_enable_bit, // channel enable
  input wire logic arb_pick, // arbiter picked external channel
  input wire logic other_req_pending, // another dma request pending
  input wire logic burst_done, // channel engine finished burst
  output logic ext_grant_n, // grant to peripheral, active low
  output logic ext_pending, // request to arbiter
  output logic burst_start, // start burst on channel, pulse
  output logic ext_low_prio // lower priority next arbitration
);
  import dxrh_pkg::*;

  // hold counter is four bits wide, so refuse what it cannot count
  if (GRANT_MIN_CYC < 1 || GRANT_MIN_CYC > 15) begin : g_bad_hold
    $error("grant hold count out of range");
  end

  dxrh_state_t state;
  dxrh_state_t next_state;
  logic req_sync;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic granted;
  logic next_granted;
  logic next_low_prio;

  // raw pin is asynchronous; only the filtered level reaches the fsm
  dxrh_sync u_req_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(ext_req_pin),
    .sync_out(req_sync)
  ); // [R15]

  // channel setup decode
  wire chan_ext = (request_source_select == ext_source_code); // [R5]
  wire chan_on = request_enable_bit & channel_enable_bit; // [R6]
  wire chan_ready = chan_ext & chan_on;

  // state decode
  wire in_idle = (state == DXRH_IDLE);

  // request accepted only while idle, ignored from grant to burst end
  wire accept = in_idle & req_sync & chan_ready; // [R8]
  wire start_now = accept & arb_pick; // [R1]
  wire grant_cond = chan_ready & req_sync; // [R5] [R6] [R7]
  wire pend_now = accept & ~start_now; // [R1]

  // hold window decode
  wire [3:0] hold_last = 4'(GRANT_MIN_CYC - 1);
  wire hold_done = (hold_cnt == hold_last);
  wire hold_step = granted & ~hold_done; // [R10] [R14]
  wire late_grant = ~granted & grant_cond; // [R7]
  wire end_to_hold = burst_done & hold_step;
  wire end_to_idle = burst_done & ~hold_step;

  // priority drop; a start in the same cycle wins over the clear
  wire prio_clear = in_idle & ~other_req_pending;

  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_granted = granted;
    case (state)
      DXRH_IDLE: begin
        next_granted = 1'b0;
        if (start_now) begin
          next_state = DXRH_BURST; // [R3]
          next_hold_cnt = DXRH_CNT_RESET;
          next_granted = grant_cond;
        end
      end
      DXRH_BURST: begin
        // grant is raised with the start, so granted is already set here and late_grant never fires
        if (hold_step) begin
          next_hold_cnt = hold_cnt + 4'h1; // [R10] [R14]
        end
        if (late_grant) begin
          next_granted = 1'b1; // [R7]
        end
        if (end_to_hold) begin
          next_state = DXRH_HOLD; // [R10]
        end else if (end_to_idle) begin
          next_state = DXRH_IDLE;
          next_granted = 1'b0;
        end
      end
      DXRH_HOLD: begin
        // burst is over but grant must still stand its minimum
        if (hold_done) begin
          next_state = DXRH_IDLE;
          next_granted = 1'b0;
        end else begin
          next_hold_cnt = hold_cnt + 4'h1; // [R10]
        end
      end
      default: begin
        next_state = DXRH_IDLE;
        next_hold_cnt = DXRH_CNT_RESET;
        next_granted = 1'b0;
      end
    endcase
  end

  // low priority lasts until idle with nothing else waiting
  always_comb begin
    next_low_prio = ext_low_prio;
    if (start_now) begin
      next_low_prio = other_req_pending; // [R9]
    end else if (prio_clear) begin
      next_low_prio = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= DXRH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= DXRH_CNT_RESET;
    end else begin
      hold_cnt <= next_hold_cnt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      granted <= 1'b0;
    end else begin
      granted <= next_granted;
    end
  end

  // outputs straight from flops, so the pins see no decode glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_grant_n <= 1'b1;
    end else begin
      ext_grant_n <= ~next_granted; // [R4]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_pending <= 1'b0;
    end else begin
      ext_pending <= pend_now; // [R1]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      burst_start <= 1'b0;
    end else begin
      burst_start <= start_now; // [R3]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_low_prio <= 1'b0;
    end else begin
      ext_low_prio <= next_low_prio; // [R9]
    end
  end
endmodule : dxrh_handshake

// File: core/dxrh_pkg.sv
/*
  constants and types for the external dma request / grant handshake block.
  assumes a single system bus clock at 125 mhz drives everything.
*/
package dxrh_pkg;
  localparam int DXRH_CLK_MHZ = 125;
  localparam int DXRH_CLK_PERIOD_PS = 8000;
  // grant hold is counted in bus clocks
  localparam int DXRH_GRANT_MIN_HCLK = 8;
  localparam int DXRH_GRANT_MIN_CYC = DXRH_GRANT_MIN_HCLK;
  localparam int DXRH_SYNC_STAGES = 3;
  localparam int DXRH_CHANNELS = 16;
  localparam int DXRH_SRC_W = 6;
  localparam logic [5:0] DXRH_SRC_RESET = 6'h00;
  localparam logic [5:0] DXRH_SRC_EXT_DEFAULT = 6'h00;
  localparam logic [3:0] DXRH_CNT_RESET = 4'h0;
  typedef enum logic [1:0] {
    DXRH_IDLE,
    DXRH_BURST,
    DXRH_HOLD
  } dxrh_state_t;
endpackage : dxrh_pkg

// File: core/dxrh_sync.sv
/*
  three-stage synchroniser with agreement of the last two stages.
  assumes the input is asynchronous to clock.
*/
module dxrh_sync (
  input wire logic clock, // system bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic async_in, // raw pin level
  output logic sync_out // filtered level
);
  logic s1;
  logic s2;
  logic s3;
  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule : dxrh_sync

// File: tb/dxrh_properties.sv
/* port checker for dxrh_handshake, bound into every instance.
   assumes one clock domain and a peripheral that holds its request. */
module dxrh_properties
  import dxrh_pkg::*;
#(
  parameter int GRANT_MIN_CYC = DXRH_GRANT_MIN_CYC
) (
  input wire logic clock, // bus clock
  input wire logic rst_n, // async reset
  input wire logic ext_req_pin, // raw request
  input wire logic [DXRH_SRC_W-1:0] request_source_select, // source
  input wire logic [DXRH_SRC_W-1:0] ext_source_code, // ext code
  input wire logic request_enable_bit, // req enable
  input wire logic channel_enable_bit, // ch enable
  input wire logic arb_pick, // arbiter pick
  input wire logic other_req_pending, // other req
  input wire logic ext_grant_n, // grant
  input wire logic burst_start, // start pulse
  input wire logic ext_low_prio // low priority
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lowcnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // cycles of grant seen low so far, cleared when grant is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lowcnt <= 8'h00;
    else lowcnt <= ext_grant_n ? 8'h00 : lowcnt + 8'h01;
  end
  a_start_needs_pick: assert property (burst_start |-> $past(arb_pick))
    else $error("burst started without arbiter pick");
  a_start_one_pulse: assert property (burst_start |=> !burst_start)
    else $error("start pulse too long");
  a_start_source_ok: assert property (burst_start |-> $past(request_enable_bit
    && channel_enable_bit && request_source_select == ext_source_code))
    else $error("burst on channel not set up for external request");
  a_start_synced_req: assert property (burst_start |-> $past(ext_req_pin, 3))
    else $error("start faster than the synchroniser");
  a_grant_needs_req: assert property ($fell(ext_grant_n) |-> $past(ext_req_pin, 3))
    else $error("grant without request");
  a_grant_min_hold: assert property ($rose(ext_grant_n) |-> lowcnt >= GRANT_MIN_CYC)
    else $error("grant released too early");
  a_no_start_granted: assert property (!ext_grant_n && $past(!ext_grant_n) |-> !burst_start)
    else $error("new burst while granted");
  a_low_prio_next: assert property (burst_start && $past(other_req_pending) |-> ##[0:1] ext_low_prio)
    else $error("priority not lowered");
  c_burst: cover property (burst_start);
  c_low: cover property (burst_start ##1 ext_low_prio);
  c_hold: cover property ($rose(ext_grant_n));
endmodule : dxrh_properties

bind dxrh_handshake dxrh_properties #(.GRANT_MIN_CYC(GRANT_MIN_CYC)) u_chk (.*);

// File: tb/dxrh_periph.sv
/* requesting peripheral model: raises request while go is high.
   assumes dly stays below 4 so release lands inside the safe window. */
module dxrh_periph (
  input wire logic clock, // bus clock
  input wire logic go, // want service
  input wire logic [3:0] dly, // release delay
  input wire logic ext_grant_n, // grant seen
  output logic req // request pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic seen;
  initial req = 1'b0;
  always @(negedge clock) begin
    if (!go) begin
      req <= 1'b0;
      seen <= 1'b0;
      cnt <= 4'h0;
    end else if (!seen) begin
      req <= 1'b1;
      seen <= !ext_grant_n;
    end else if (cnt == dly) req <= 1'b0;
    else cnt <= cnt + 4'h1;
  end
endmodule : dxrh_periph

// File: tb/tb_top.sv
/* random trials of accepted and refused external requests.
   assumes the default grant minimum and the partner model. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dxrh_pkg::*;
  logic clock, rst_n, ext_req_pin, request_enable_bit, channel_enable_bit;
  logic arb_pick, other_req_pending, burst_done, ext_grant_n, ext_pending;
  logic burst_start, ext_low_prio, go;
  logic [DXRH_SRC_W-1:0] request_source_select, ext_source_code;
  logic [3:0] dly;
  logic [31:0] seed, r;
  logic [1:0] q[$];
  int bad_count, num_checks, k, n, dd, m;
  dxrh_handshake DUT (.*);
  dxrh_periph u_per (.clock, .go, .dly, .ext_grant_n, .req(ext_req_pin));
  always #4 clock = ~clock;
  task check(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task tmo(input int lim);
    if (k >= lim) begin
      check(2'h0, 2'h1);
      results();
    end
  endtask : tmo
  // expected grant and priority one cycle after each start
  always @(negedge clock) if (burst_start === 1'b1) begin
    @(negedge clock);
    if (q.size() == 0) check(2'h0, 2'h1);
    else check({ext_grant_n, ext_low_prio}, q.pop_front());
  end
  initial begin
    {clock, rst_n, go, arb_pick, other_req_pending, burst_done} = 6'h00;
    {request_enable_bit, channel_enable_bit, dly} = 6'h00;
    {request_source_select, ext_source_code} = 12'h000;
    seed = 32'ha5cc205a;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      m = r[1:0];
      ext_source_code = r[7:2];
      request_source_select = (m == 1) ? ~r[7:2] : r[7:2];
      request_enable_bit = (m != 2);
      channel_enable_bit = (m != 3);
      other_req_pending = r[8];
      dly = {2'b00, r[10:9]};
      dd = 1 + r[14:11] % 12;
      go = 1'b1;
      if (m == 0) begin
        for (k = 0; k < 20 && ext_pending !== 1'b1; k++) @(negedge clock);
        tmo(20);
        q.push_back({1'b0, r[8]});
        arb_pick = 1'b1;
        n = 0;
        for (k = 0; k < 40 && !(n > 0 && ext_grant_n === 1'b1); k++) begin
          @(negedge clock);
          arb_pick = 1'b0;
          burst_done = (k == dd);
          if (ext_grant_n === 1'b0) n++;
        end
        tmo(40);
        check(n >= DXRH_GRANT_MIN_CYC, 1'b1);
      end else begin
        repeat (12) @(negedge clock);
        check({ext_pending, ext_grant_n}, 2'b01);
      end
      go = 1'b0;
      repeat (8) @(negedge clock);
      $display("trial %0d mode %0d done", i, m);
    end
    check(q.size() == 0, 1'b1);
    results();
  end
endmodule : tb_top
